/* inc/xcsd_pkg.sv */
// constants for the expansion-bus chip select decoder
//
// Behaviour
// - cleared enable blocks select and output enable
// - bit 10 enables microcontroller select, decode 62h/66h
// - bit 9 forwards 1-Meg extended BIOS region
// - bit 7 forwards 384K extended BIOS region
// - top BIOS forwards drive upper ISA address ones
// - bit 6 selects lower BIOS and alias
// - lower BIOS disabled: no select, no forward
// - bit 8 selects and forwards I/O APIC region
// - APIC disabled: ignore cycle, no select
// - never APIC select for ISA master cycles
// - APIC enable swaps six pins with GPIO
// - bit 5 error input raises IRQ13, gates ignore
// - bit 4 picks mouse or standard IRQ12
// - bit 3 aliases 63h/65h/67h to 61h
// - bit 2 allows BIOS select on writes
// - bit 1 enables keyboard select at 60h/64h
// - bit 0 enables clock chip select at 70-77h
package xcsd_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0]  ESC_OFFSET      = 8'h4e;  // expansion_select_control
  localparam logic [7:0]  APIC_BASE_OFF   = 8'h80;  // apic window base
  localparam logic [7:0]  GPIO_OFF        = 8'h84;  // gpio in/out
  localparam logic [15:0] ESC_RESET       = 16'h0003;
  localparam logic [15:0] ESC_WMASK       = 16'h07ff;
  localparam logic [31:0] APIC_BASE_RESET = 32'hfec0_0000;
  localparam logic [31:0] APIC_WIN_MASK   = 32'hffff_ffe0;
  // ==========================================================================
  // control bit positions
  localparam int B_RTC   = 0;
  localparam int B_KBC   = 1;
  localparam int B_BWR   = 2;
  localparam int B_P61   = 3;
  localparam int B_MOUSE = 4;
  localparam int B_COPROCESSOR_ERROR_N  = 5;
  localparam int B_LBIOS = 6;
  localparam int B_XBIOS = 7;
  localparam int B_APIC  = 8;
  localparam int B_MBIOS = 9;
  localparam int B_MC    = 10;
  // ==========================================================================
  // decoded addresses
  localparam logic [15:0] IO_KBC_DATA = 16'h0060;
  localparam logic [15:0] IO_P61      = 16'h0061;
  localparam logic [15:0] IO_MC_DATA  = 16'h0062;
  localparam logic [15:0] IO_P63      = 16'h0063;
  localparam logic [15:0] IO_KBC_CMD  = 16'h0064;
  localparam logic [15:0] IO_P65      = 16'h0065;
  localparam logic [15:0] IO_MC_CMD   = 16'h0066;
  localparam logic [15:0] IO_P67      = 16'h0067;
  localparam logic [15:0] IO_RTC_LO   = 16'h0070;
  localparam logic [15:0] IO_RTC_HI   = 16'h0077;
  localparam logic [15:0] IO_FPU_CLR  = 16'h00f0;
  localparam logic [31:0] MBIOS_LO    = 32'hfff0_0000;
  localparam logic [31:0] MBIOS_HI    = 32'hfff7_ffff;
  localparam logic [31:0] XBIOS_LO    = 32'hfff8_0000;
  localparam logic [31:0] XBIOS_HI    = 32'hfffd_ffff;
  localparam logic [31:0] LBIOS_LO    = 32'h000e_0000;
  localparam logic [31:0] LBIOS_HI    = 32'h000e_ffff;
  localparam logic [31:0] LBIOS_AL_LO = 32'hfffe_0000;
  localparam logic [31:0] LBIOS_AL_HI = 32'hfffe_ffff;
  localparam logic [3:0]  LA_TOP      = 4'hf;
  localparam int          APIC_PINS   = 6;
endpackage

/* rtl/xcsd_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module xcsd_sync #(
  parameter int          W     = 1,
  parameter logic [W-1:0] RST_V = '0
) (
  input  wire logic         core_clk, // clock
  input  wire logic         rst,      // async reset
  input  wire logic [W-1:0] d,        // raw pin
  output logic      [W-1:0] q         // synchronised
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_V;
      q      <= RST_V;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/xcsd_range.sv */
// inclusive address range comparator
`timescale 1ns/1ns
`default_nettype none
module xcsd_range #(
  parameter logic [31:0] LO = 32'h0000_0000,
  parameter logic [31:0] HI = 32'h0000_0000
) (
  input  wire logic [31:0] addr, // address under test
  output logic             hit   // inside range
);
  assign hit = (addr >= LO) && (addr <= HI);
endmodule
`default_nettype wire

/* rtl/xcsd_top.sv */
// expansion-bus chip select decoder with control register
`timescale 1ns/1ns
`default_nettype none
module xcsd_top (
  input  wire logic        core_clk,                // 100 MHz clock
  input  wire logic        rst,                     // async reset, high
  // register port
  input  wire logic [7:0]  reg_addr,                // byte offset
  input  wire logic [15:0] reg_wdata,               // write data
  input  wire logic        reg_wr,                  // write strobe
  input  wire logic        reg_rd,                  // read strobe
  output logic      [15:0] reg_rdata,               // read data, next cycle
  // bus cycle in progress
  input  wire logic        cyc_active,              // cycle present, level
  input  wire logic [31:0] cyc_addr,                // cycle address
  input  wire logic        cyc_io,                  // 1 io, 0 memory
  input  wire logic        cyc_write,               // 1 write
  input  wire logic        cyc_isa_master,          // 1 isa master origin
  // decode results
  output logic             clock_chip_select_n,     // clock chip select
  output logic             clock_chip_addr_latch,   // clock chip index latch
  output logic             keyboard_ctrl_select_n,  // keyboard ctrl select
  output logic             microcontroller_select_n,// microcontroller select
  output logic             boot_rom_select_n,       // boot rom select
  output logic             ioapic_select_n,         // io apic select
  output logic             expansion_output_enable_n,// shared output enable
  output logic             pci_claim,               // positive decode
  output logic             fwd_to_isa,              // forward to isa
  output logic      [3:0]  isa_la_hi,               // isa address 23:20
  output logic             port61_hit,              // access goes to 61h
  // coprocessor and mouse
  input  wire logic        coprocessor_error_n,     // error pin
  output logic             irq13_int,               // internal irq13
  output logic             ignore_numeric_error_n,  // ignore error pin
  input  wire logic        mouse_interrupt_pin,     // irq12 pin
  output logic             mouse_irq,               // mouse function irq
  output logic             irq12_std,               // standard irq12
  // apic pins as gpio
  output logic             apic_pin_mode,           // 1 apic, 0 gpio
  input  wire logic [5:0]  apic_gpio_in,            // pin levels
  output logic      [5:0]  apic_gpio_out,           // pin drive
  output logic      [5:0]  apic_gpio_oe             // pin drive enable
);
  // ==========================================================================
  // registers
  logic [15:0] ctrl_q, ctrl_d;
  logic [31:0] apic_base_q, apic_base_d;
  logic [5:0]  gpio_out_q, gpio_out_d;
  logic [5:0]  gpio_dir_q, gpio_dir_d;
  logic [15:0] rdata_q, rdata_d;

  logic        coprocessor_error_n_s_n;
  logic        irq12_s;
  logic [5:0]  gpio_s;

  // pins come from outside the clock domain: two flops before any use
  xcsd_sync #(.W(1), .RST_V(1'b1)) u_coprocessor_error_n_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (coprocessor_error_n),
    .q        (coprocessor_error_n_s_n)
  );

  xcsd_sync #(.W(1), .RST_V(1'b0)) u_irq12_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (mouse_interrupt_pin),
    .q        (irq12_s)
  );

  xcsd_sync #(.W(6), .RST_V(6'h00)) u_gpio_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (apic_gpio_in),
    .q        (gpio_s)
  );

  // ==========================================================================
  // register write and read decode
  // unmapped offsets write nothing; a read answers once, then the word is zero
  always_comb
  begin
    ctrl_d      = ctrl_q;
    apic_base_d = apic_base_q;
    gpio_out_d  = gpio_out_q;
    gpio_dir_d  = gpio_dir_q;
    rdata_d     = 16'h0000;
    if (reg_wr)
    begin
      unique case (reg_addr)
        xcsd_pkg::ESC_OFFSET:
          ctrl_d = reg_wdata & xcsd_pkg::ESC_WMASK;
        xcsd_pkg::APIC_BASE_OFF:
          apic_base_d = {reg_wdata, 16'h0000} & xcsd_pkg::APIC_WIN_MASK;
        xcsd_pkg::GPIO_OFF:
        begin
          gpio_out_d = reg_wdata[5:0];
          gpio_dir_d = reg_wdata[13:8];
        end
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        xcsd_pkg::ESC_OFFSET:    rdata_d = ctrl_q & xcsd_pkg::ESC_WMASK;
        xcsd_pkg::APIC_BASE_OFF: rdata_d = apic_base_q[31:16];
        xcsd_pkg::GPIO_OFF:      rdata_d = {2'b00, gpio_dir_q, 2'b00, gpio_s};
        default:                 rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q      <= xcsd_pkg::ESC_RESET;
      apic_base_q <= xcsd_pkg::APIC_BASE_RESET;
      gpio_out_q  <= 6'h00;
      gpio_dir_q  <= 6'h00;
      rdata_q     <= 16'h0000;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      apic_base_q <= apic_base_d;
      gpio_out_q  <= gpio_out_d;
      gpio_dir_q  <= gpio_dir_d;
      rdata_q     <= rdata_d;
    end
  end

  // ==========================================================================
  // address decode
  logic hit_mbios, hit_xbios, hit_lbios, hit_lbios_al;

  xcsd_range #(.LO(xcsd_pkg::MBIOS_LO), .HI(xcsd_pkg::MBIOS_HI)) u_r_mbios (
    .addr (cyc_addr),
    .hit  (hit_mbios)
  );
  xcsd_range #(.LO(xcsd_pkg::XBIOS_LO), .HI(xcsd_pkg::XBIOS_HI)) u_r_xbios (
    .addr (cyc_addr),
    .hit  (hit_xbios)
  );
  xcsd_range #(.LO(xcsd_pkg::LBIOS_LO), .HI(xcsd_pkg::LBIOS_HI)) u_r_lbios (
    .addr (cyc_addr),
    .hit  (hit_lbios)
  );
  xcsd_range #(.LO(xcsd_pkg::LBIOS_AL_LO), .HI(xcsd_pkg::LBIOS_AL_HI)) u_r_lbal (
    .addr (cyc_addr),
    .hit  (hit_lbios_al)
  );

  logic [15:0] io_a;
  logic        io_cyc, mem_cyc, pci_cyc;
  logic        rtc_d, ale_d, kbc_d, mc_d, bios_reg_d, bios_d, apic_d;
  logic        top_bios_d, fwd_d, p61_d, fpu_clr;

  always_comb
  begin
    // io decode looks at the low sixteen address bits only
    io_a    = cyc_addr[15:0];
    io_cyc  = cyc_active && cyc_io;
    mem_cyc = cyc_active && !cyc_io;
    pci_cyc = !cyc_isa_master;
    rtc_d   = io_cyc && ctrl_q[xcsd_pkg::B_RTC] &&
              io_a >= xcsd_pkg::IO_RTC_LO && io_a <= xcsd_pkg::IO_RTC_HI;
    // index ports are the even ones: those writes strobe the latch
    ale_d   = rtc_d && cyc_write && !io_a[0];
    kbc_d   = io_cyc && ctrl_q[xcsd_pkg::B_KBC] &&
              (io_a == xcsd_pkg::IO_KBC_DATA || io_a == xcsd_pkg::IO_KBC_CMD);
    mc_d    = io_cyc && ctrl_q[xcsd_pkg::B_MC] &&
              (io_a == xcsd_pkg::IO_MC_DATA || io_a == xcsd_pkg::IO_MC_CMD);
    p61_d   = io_cyc && (io_a == xcsd_pkg::IO_P61 ||
              (ctrl_q[xcsd_pkg::B_P61] && (io_a == xcsd_pkg::IO_P63 ||
               io_a == xcsd_pkg::IO_P65 || io_a == xcsd_pkg::IO_P67)));
    top_bios_d = mem_cyc && pci_cyc &&
                 ((ctrl_q[xcsd_pkg::B_MBIOS] && hit_mbios) ||
                  (ctrl_q[xcsd_pkg::B_XBIOS] && hit_xbios) ||
                  (ctrl_q[xcsd_pkg::B_LBIOS] && hit_lbios_al));
    bios_reg_d = top_bios_d ||
                 (mem_cyc && ctrl_q[xcsd_pkg::B_LBIOS] && hit_lbios);
    // write protect: without bit 2 a write gets no select at all
    bios_d  = bios_reg_d && (!cyc_write || ctrl_q[xcsd_pkg::B_BWR]);
    // the 32-byte window holds both default apic addresses under one base
    apic_d  = mem_cyc && pci_cyc && ctrl_q[xcsd_pkg::B_APIC] &&
              ((cyc_addr & xcsd_pkg::APIC_WIN_MASK) == apic_base_q);
    // isa-originated cycles are already on isa; only pci ones are forwarded
    fwd_d   = top_bios_d || apic_d ||
              (bios_reg_d && pci_cyc && hit_lbios);
    // a write to the clear port arms the ignore output while the error stands
    fpu_clr = io_cyc && cyc_write && io_a == xcsd_pkg::IO_FPU_CLR;
  end

  // ==========================================================================
  // select outputs, registered
  // selects are registered in their active-low form, so every pin leaves
  // straight from a flop with no gate behind it
  logic       rtc_n_q, kbc_n_q, mc_n_q, bios_n_q, apic_n_q, xoe_n_q;
  logic       ale_q, claim_q, fwd_q, p61_q;
  logic [3:0] la_q, la_d;

  always_comb
  begin
    // top windows alias to the top of the 16-Mbyte isa space
    la_d = top_bios_d ? xcsd_pkg::LA_TOP : cyc_addr[23:20];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rtc_n_q  <= 1'b1;
      ale_q    <= 1'b0;
      kbc_n_q  <= 1'b1;
      mc_n_q   <= 1'b1;
      bios_n_q <= 1'b1;
      apic_n_q <= 1'b1;
      xoe_n_q  <= 1'b1;
      claim_q <= 1'b0;
      fwd_q   <= 1'b0;
      p61_q   <= 1'b0;
      la_q    <= 4'h0;
    end
    else
    begin
      rtc_n_q  <= !rtc_d;
      ale_q    <= ale_d;
      kbc_n_q  <= !kbc_d;
      mc_n_q   <= !mc_d;
      bios_n_q <= !bios_d;
      apic_n_q <= !apic_d;
      xoe_n_q  <= !(rtc_d || kbc_d || mc_d || bios_d || apic_d);
      claim_q <= mc_d && pci_cyc;
      fwd_q   <= fwd_d;
      p61_q   <= p61_d;
      la_q    <= la_d;
    end
  end

  assign clock_chip_select_n       = rtc_n_q;
  assign clock_chip_addr_latch     = ale_q;
  assign keyboard_ctrl_select_n    = kbc_n_q;
  assign microcontroller_select_n  = mc_n_q;
  assign boot_rom_select_n         = bios_n_q;
  assign ioapic_select_n           = apic_n_q;
  assign expansion_output_enable_n = xoe_n_q;
  assign pci_claim                 = claim_q;
  assign fwd_to_isa                = fwd_q;
  assign isa_la_hi                 = la_q;
  assign port61_hit                = p61_q;
  assign reg_rdata                 = rdata_q;

  // ==========================================================================
  // coprocessor error, mouse irq, apic pin mode
  logic coprocessor_error_n_act, ign_n_q, ign_d, irq13_q, irq13_d;
  logic mouse_q, mouse_d, std_q, std_d, mode_q;
  logic [5:0] gout_q, goe_q, goe_d;

  always_comb
  begin
    coprocessor_error_n_act = ctrl_q[xcsd_pkg::B_COPROCESSOR_ERROR_N] && !coprocessor_error_n_s_n;
    irq13_d  = coprocessor_error_n_act;
    // ignore is armed by the clear write and held only while error stays
    ign_d    = coprocessor_error_n_act && (!ign_n_q || fpu_clr);
    mouse_d  = ctrl_q[xcsd_pkg::B_MOUSE] && irq12_s;
    std_d    = !ctrl_q[xcsd_pkg::B_MOUSE] && irq12_s;
    // the pins are never driven while the apic function owns them; mode and
    // drive enables follow the control bit one cycle late
    goe_d    = ctrl_q[xcsd_pkg::B_APIC] ? 6'h00 : gpio_dir_q;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq13_q <= 1'b0;
      ign_n_q <= 1'b1;
      mouse_q <= 1'b0;
      std_q   <= 1'b0;
      mode_q  <= 1'b0;
      gout_q  <= 6'h00;
      goe_q   <= 6'h00;
    end
    else
    begin
      irq13_q <= irq13_d;
      ign_n_q <= !ign_d;
      mouse_q <= mouse_d;
      std_q   <= std_d;
      mode_q  <= ctrl_q[xcsd_pkg::B_APIC];
      gout_q  <= gpio_out_q;
      goe_q   <= goe_d;
    end
  end

  assign irq13_int              = irq13_q;
  assign ignore_numeric_error_n = ign_n_q;
  assign mouse_irq              = mouse_q;
  assign irq12_std              = std_q;
  assign apic_pin_mode          = mode_q;
  assign apic_gpio_out          = gout_q;
  assign apic_gpio_oe           = goe_q;
endmodule
`default_nettype wire

/* verification/xcsd_properties.sv */
// concurrent checks of the decoder top-level ports
`timescale 1ns/1ns
`default_nettype none
module xcsd_properties (
  input wire logic        core_clk,                  // clock
  input wire logic        rst,                       // reset
  input wire logic [7:0]  reg_addr,                  // offset
  input wire logic [15:0] reg_wdata,                 // wdata
  input wire logic        reg_wr,                    // write
  input wire logic        reg_rd,                    // read
  input wire logic [15:0] reg_rdata,                 // rdata
  input wire logic        cyc_active,                // cycle
  input wire logic [31:0] cyc_addr,                  // address
  input wire logic        cyc_io,                    // io
  input wire logic        cyc_write,                 // write
  input wire logic        cyc_isa_master,            // isa origin
  input wire logic        clock_chip_select_n,       // rtc
  input wire logic        keyboard_ctrl_select_n,    // kbc
  input wire logic        microcontroller_select_n,  // mc
  input wire logic        boot_rom_select_n,         // bios
  input wire logic        ioapic_select_n,           // apic
  input wire logic        expansion_output_enable_n, // xoe
  input wire logic        pci_claim,                 // claim
  input wire logic        fwd_to_isa,                // forward
  input wire logic [3:0]  isa_la_hi                  // la 23:20
);
  // ==========================================================================
  // shadow of the control register
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  always_comb
  begin
    ctl_d = ctl_q;
    if (reg_wr && reg_addr == xcsd_pkg::ESC_OFFSET)
      ctl_d = reg_wdata & xcsd_pkg::ESC_WMASK;
  end
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      ctl_q <= xcsd_pkg::ESC_RESET;
    else
      ctl_q <= ctl_d;
  wire logic        io_c = cyc_active && cyc_io;
  wire logic        pm_c = cyc_active && !cyc_io && !cyc_isa_master;
  wire logic [15:0] ioa  = cyc_addr[15:0];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_io(logic [15:0] a);
    io_c && ioa == a;
  endsequence
  // ==========================================================================
  // decode checks, outputs follow one cycle after the cycle
  a_kbc_select: assert property ((s_io(16'h0060) or s_io(16'h0064)) |=>
    keyboard_ctrl_select_n == !$past(ctl_q[1])) else $error("keyboard select wrong");
  a_rtc_select: assert property (io_c && ioa inside {[16'h0070:16'h0077]} |=>
    clock_chip_select_n == !$past(ctl_q[0])) else $error("clock select wrong");
  a_mc_select: assert property ((s_io(16'h0062) or s_io(16'h0066)) ##0 !cyc_isa_master |=>
    microcontroller_select_n == !$past(ctl_q[10]) && pci_claim == $past(ctl_q[10]))
    else $error("microcontroller decode wrong");
  a_oe_shared: assert property (expansion_output_enable_n == (clock_chip_select_n &&
    keyboard_ctrl_select_n && microcontroller_select_n && boot_rom_select_n &&
    ioapic_select_n)) else $error("output enable not tied to selects");
  a_apic_isa: assert property (cyc_active && cyc_isa_master |=> ioapic_select_n)
    else $error("apic select on isa cycle");
  a_xbios_sel: assert property (pm_c && !cyc_write &&
    cyc_addr inside {[xcsd_pkg::XBIOS_LO:xcsd_pkg::XBIOS_HI]} |=>
    boot_rom_select_n == !$past(ctl_q[7]) && (!$past(ctl_q[7]) || isa_la_hi == 4'hf))
    else $error("extended bios decode wrong");
  a_lbios_off: assert property (cyc_active && !cyc_io && !ctl_q[6] &&
    cyc_addr inside {[xcsd_pkg::LBIOS_LO:xcsd_pkg::LBIOS_HI]} |=>
    boot_rom_select_n && !fwd_to_isa) else $error("lower bios active while off");
  a_bios_wprot: assert property (cyc_active && !cyc_io && cyc_write && !ctl_q[2] |=>
    boot_rom_select_n) else $error("bios select on protected write");
  a_rsvd_zero: assert property (reg_rd && reg_addr == xcsd_pkg::ESC_OFFSET |=>
    reg_rdata[15:11] == 5'h00) else $error("reserved bits not zero");
endmodule
bind xcsd_top xcsd_properties u_props (.*);
`default_nettype wire

/* verification/xcsd_master_model.sv */
// bus master model presenting pci and isa cycles to the decoder
`timescale 1ns/1ns
`default_nettype none
module xcsd_master_model (
  input  wire logic        core_clk,       // clock
  input  wire logic        rst,            // reset
  input  wire logic        req,            // present one cycle
  input  wire logic [31:0] req_addr,       // address
  input  wire logic [2:0]  req_kind,       // isa, write, io
  output logic             cyc_active,     // cycle present
  output logic      [31:0] cyc_addr,       // address
  output logic             cyc_io,         // io cycle
  output logic             cyc_write,      // write cycle
  output logic             cyc_isa_master  // isa origin
);
  // ==========================================================================
  // one-cycle bus presentation
  logic [35:0] bus_d;
  logic [35:0] bus_q;
  always_comb
  begin
    // idle lines toggle so a stale address never looks held
    bus_d = req ? {1'b1, req_kind, req_addr} : {1'b0, ~bus_q[34:0]};
  end
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      bus_q <= '0;
    else
      bus_q <= bus_d;
  // no isa memory is modelled, so nothing answers in the bios alias windows
  assign {cyc_active, cyc_isa_master, cyc_write, cyc_io, cyc_addr} = bus_q;
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the expansion-bus chip select decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        req = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic [2:0]  req_kind = 3'h0;
  logic        coprocessor_error_n = 1'b1;
  logic        mouse_interrupt_pin = 1'b0;
  logic [5:0]  apic_gpio_in = 6'h00;
  logic [15:0] reg_rdata;
  logic        cyc_active, cyc_io, cyc_write, cyc_isa_master;
  logic [31:0] cyc_addr;
  logic        clock_chip_select_n, clock_chip_addr_latch, keyboard_ctrl_select_n;
  logic        microcontroller_select_n, boot_rom_select_n, ioapic_select_n;
  logic        expansion_output_enable_n, pci_claim, fwd_to_isa, port61_hit;
  logic        irq13_int, ignore_numeric_error_n, mouse_irq, irq12_std, apic_pin_mode;
  logic [3:0]  isa_la_hi;
  logic [5:0]  apic_gpio_out, apic_gpio_oe;
  int          bad_count = 0;
  int          tests_run = 0;
  wire logic [5:0] sel = {clock_chip_select_n, keyboard_ctrl_select_n,
    microcontroller_select_n, boot_rom_select_n, ioapic_select_n, expansion_output_enable_n};
  localparam logic [2:0] IO = 3'b001;
  localparam logic [2:0] MR = 3'b000;
  localparam logic [2:0] MW = 3'b010;
  localparam logic [2:0] IR = 3'b100;
  localparam logic [2:0] IW = 3'b011;
  always #5 core_clk = ~core_clk;
  xcsd_master_model u_master (.*);
  xcsd_top u_dut (.*);
  // ==========================================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
  begin
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
  begin
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  end
  endtask
  // present one cycle and judge the selects a cycle after the master presents it
  task automatic go(input logic [31:0] a, input logic [2:0] k, input logic [5:0] e);
  begin
    @(posedge core_clk);
    req <= 1'b1;
    req_addr <= a;
    req_kind <= k;
    @(posedge core_clk);
    req <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(sel, e)
  end
  endtask
  task automatic complete_run;
  begin
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs;
  begin
    rd(8'h4e, 16'h0003);
    wr(8'h4e, 16'hffff);
    rd(8'h4e, 16'h07ff);
    rd(8'h10, 16'h0000);
    $display("test regs done");
  end
  endtask
  task automatic t_io;
    logic [15:0] a [6] = '{16'h60, 16'h64, 16'h62, 16'h66, 16'h70, 16'h77};
    logic [5:0]  e [6] = '{6'h2e, 6'h2e, 6'h36, 6'h36, 6'h1e, 6'h1e};
  begin
    wr(8'h4e, 16'h0000);
    for (int i = 0; i < 6; i++)
      go({16'h0, a[i]}, IO, 6'h3f);
    wr(8'h4e, 16'h0403);
    for (int i = 0; i < 6; i++)
      go({16'h0, a[i]}, IO, e[i]);
    go(32'h70, IW, 6'h1e);
    `CHK(clock_chip_addr_latch, 1'b1)
    go(32'h71, IW, 6'h1e);
    `CHK(clock_chip_addr_latch, 1'b0)
    go(32'h66, IO, 6'h36);
    `CHK(pci_claim, 1'b1)
    go(32'h78, IO, 6'h3f);
    for (int b = 0; b < 2; b++)
    begin
      wr(8'h4e, b[0] ? 16'h0008 : 16'h0000);
      for (int i = 0; i < 3; i++)
      begin
        go(32'(32'h63 + 2 * i), IO, 6'h3f);
        `CHK(port61_hit, b[0])
      end
    end
    $display("test io done");
  end
  endtask
  task automatic t_bios;
    logic [31:0] a [4] = '{32'hfff00000, 32'hfff80000, 32'hfffdffff, 32'hfffe0000};
  begin
    wr(8'h4e, 16'h02c4);
    for (int i = 0; i < 4; i++)
    begin
      go(a[i], MR, 6'h3a);
      `CHK({fwd_to_isa, isa_la_hi}, 5'h1f)
    end
    go(32'h000e0000, IR, 6'h3a);
    go(32'h000e8000, MW, 6'h3a);
    wr(8'h4e, 16'h02c0);
    go(32'hfff00000, MW, 6'h3f);
    wr(8'h4e, 16'h0004);
    for (int i = 0; i < 4; i++)
      go(a[i], MR, 6'h3f);
    `CHK(fwd_to_isa, 1'b0)
    go(32'h000e0000, MR, 6'h3f);
    `CHK(fwd_to_isa, 1'b0)
    $display("test bios done");
  end
  endtask
  task automatic t_apic;
  begin
    wr(8'h4e, 16'h0100);
    apic_gpio_in <= 6'h0c;
    go(32'hfec00000, MR, 6'h3c);
    `CHK(fwd_to_isa, 1'b1)
    go(32'hfec00010, MR, 6'h3c);
    go(32'hfec00000, IR, 6'h3f);
    `CHK({apic_pin_mode, apic_gpio_oe}, 7'h40)
    wr(8'h4e, 16'h0000);
    go(32'hfec00000, MR, 6'h3f);
    `CHK(apic_pin_mode, 1'b0)
    wr(8'h84, 16'h2a15);
    rd(8'h84, 16'h2a0c);
    `CHK({apic_gpio_oe, apic_gpio_out}, 12'ha95)
    wr(8'h80, 16'hfed0);
    rd(8'h80, 16'hfed0);
    wr(8'h4e, 16'h0100);
    go(32'hfed00004, MR, 6'h3c);
    go(32'hfec00000, MR, 6'h3f);
    $display("test apic done");
  end
  endtask
  task automatic t_irq;
    int n;
  begin
    wr(8'h4e, 16'h0030);
    coprocessor_error_n <= 1'b0;
    mouse_interrupt_pin <= 1'b1;
    for (n = 0; n < 8 && irq13_int !== 1'b1; n++)
      @(posedge core_clk);
    #1;
    `CHK(irq13_int, 1'b1)
    if (n == 8)
      complete_run;
    `CHK({mouse_irq, irq12_std, ignore_numeric_error_n}, 3'b101)
    go(32'hf0, IW, 6'h3f);
    `CHK(ignore_numeric_error_n, 1'b0)
    wr(8'h4e, 16'h0000);
    repeat (4) @(posedge core_clk);
    #1;
    `CHK({irq13_int, mouse_irq, irq12_std, ignore_numeric_error_n}, 4'b0011)
    coprocessor_error_n <= 1'b1;
    $display("test irq done");
  end
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_io;
    t_bios;
    t_apic;
    t_irq;
    complete_run;
  end
endmodule
`default_nettype wire
